// File: rtl/mide_consts.svh
// Purpose: named constants for the inc/dec/move/halt execution block
// Assumes: 8-bit data path, 8-bit data-memory address, 11-bit program counter
// Notes: operation codes are local to this block's command port
`ifndef MIDE_CONSTS_SVH
`define MIDE_CONSTS_SVH
`define MIDE_DATA_W 8
`define MIDE_ADDR_W 8
`define MIDE_PC_W 11
`define MIDE_MEM_DEPTH 256
`define MIDE_ONE 8'h01
`define MIDE_ZERO_BYTE 8'h00
`define MIDE_PC_RST 11'h000
`define MIDE_PC_STEP 11'h001
`define MIDE_WDT_W 16
`define MIDE_WDT_RST 16'h0000
`define MIDE_PRE_W 8
`define MIDE_PRE_RST 8'h00
`endif

// File: rtl/mide_pkg.sv
// Purpose: types shared by the execution block and its arithmetic unit
// Assumes: constants header included first
// Notes: none
`include "mide_consts.svh"
package mide_pkg;
	typedef enum logic [3:0]
	{
		MIDE_OP_NONE,
		MIDE_OP_DEC_MEM,
		MIDE_OP_DEC_WREG,
		MIDE_OP_INC_MEM,
		MIDE_OP_INC_WREG,
		MIDE_OP_JUMP,
		MIDE_OP_MOV_M2W,
		MIDE_OP_MOV_IMM,
		MIDE_OP_MOV_W2M,
		MIDE_OP_HALT
	} mide_op_t;
	typedef struct packed {
		mide_op_t op;
		logic [`MIDE_ADDR_W-1:0] addr;
		logic [`MIDE_DATA_W-1:0] imm;
		logic [`MIDE_PC_W-1:0] target;
	} mide_instr_t;
	typedef struct packed {
		logic zero;
		logic power_down_flag;
		logic watchdog_timeout_flag;
	} mide_flags_t;
	typedef enum logic [1:0]
	{
		MIDE_ST_RUN,
		MIDE_ST_DUMMY,
		MIDE_ST_HALT
	} mide_state_t;
endpackage

// File: rtl/mide_alu.sv
// Purpose: increment/decrement unit with zero detect
// Assumes: purely combinational
// Notes: results wrap modulo 256
`include "mide_consts.svh"
module mide_alu
	import mide_pkg::*;
(
	input wire logic [`MIDE_DATA_W-1:0] operand_i,
	input wire logic dec_i,
	output logic [`MIDE_DATA_W-1:0] result_o,
	output logic zero_o
);
	// wrap-around add or subtract of one, carry discarded on purpose
	always_comb
	begin
		if (dec_i)
			result_o = operand_i - `MIDE_ONE;
		else
			result_o = operand_i + `MIDE_ONE;
		zero_o = (result_o == `MIDE_ZERO_BYTE);
	end
endmodule

// File: rtl/mide_exec.sv
// Purpose: executes inc/dec, jump, move and power-down instructions
// Assumes: one instruction offered per cycle with valid, taken while ready
// Notes: data memory is held locally; wake from power-down via wake_i
`include "mide_consts.svh"
module mide_exec
	import mide_pkg::*;
(
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic instr_valid_i,
	input wire mide_instr_t instr_i,
	input wire logic wake_i,
	input wire logic watchdog_timeout_i,
	output logic ready_o,
	output logic [`MIDE_PC_W-1:0] pc_o,
	output logic [`MIDE_DATA_W-1:0] working_register_o,
	output mide_flags_t flags_o,
	output logic clk_gate_en_o,
	output logic halted_o,
	output logic [`MIDE_WDT_W-1:0] watchdog_timer_o,
	output logic [`MIDE_PRE_W-1:0] watchdog_prescaler_o,
	output logic mem_wr_o,
	output logic [`MIDE_ADDR_W-1:0] mem_addr_o,
	output logic [`MIDE_DATA_W-1:0] mem_wdata_o
);
	logic [`MIDE_DATA_W-1:0] data_mem [`MIDE_MEM_DEPTH];
	mide_state_t state;
	logic [`MIDE_DATA_W-1:0] mem_rd;
	logic [`MIDE_DATA_W-1:0] alu_res;
	logic alu_zero;
	logic alu_dec;
	logic take;
	// issue strobes for the two forms that stall the sequencer
	logic take_jump;
	logic take_halt;
	// per-bit flag registers, bundled onto flags_o
	logic zero_flag;
	logic power_down_flag;
	logic watchdog_timeout_flag;

	// instruction accepted only in the run state
	assign take = instr_valid_i && (state == MIDE_ST_RUN);
	// combinational read, so a read-modify-write finishes in the taking cycle
	assign mem_rd = data_mem[instr_i.addr];

	// jump and power-down both stall issue, so each gets its own strobe
	assign take_jump = take && (instr_i.op == MIDE_OP_JUMP);
	assign take_halt = take && (instr_i.op == MIDE_OP_HALT);

	// flags leave as one bundle; each bit keeps its own register so one process drives it
	assign flags_o = '{
		zero: zero_flag,
		power_down_flag: power_down_flag,
		watchdog_timeout_flag: watchdog_timeout_flag
	};

	// decrement for either decrement form, otherwise increment
	function automatic logic is_dec(input mide_op_t op);
		return (op == MIDE_OP_DEC_MEM) || (op == MIDE_OP_DEC_WREG);
	endfunction

	// any of the four forms that update the zero flag
	function automatic logic is_incdec(input mide_op_t op);
		return is_dec(op) || (op == MIDE_OP_INC_MEM) || (op == MIDE_OP_INC_WREG);
	endfunction

	// the three forms that store into data memory
	function automatic logic is_mem_write(input mide_op_t op);
		return (op == MIDE_OP_DEC_MEM) || (op == MIDE_OP_INC_MEM) || (op == MIDE_OP_MOV_W2M);
	endfunction

	assign alu_dec = is_dec(instr_i.op);

	// one shared unit: only one inc/dec form can be taken per cycle
	mide_alu u_alu
	(
		.operand_i(mem_rd),
		.dec_i(alu_dec),
		.result_o(alu_res),
		.zero_o(alu_zero)
	);

	// sequencer: run, jump dummy cycle, power-down
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			state <= MIDE_ST_RUN;
		else
		begin
			case (state)
				MIDE_ST_RUN:
				begin
					if (take_jump)
						state <= MIDE_ST_DUMMY;
					else if (take_halt)
						state <= MIDE_ST_HALT;
				end
				MIDE_ST_DUMMY:
					state <= MIDE_ST_RUN;
				MIDE_ST_HALT:
				begin
					if (wake_i)
						state <= MIDE_ST_RUN;
				end
				default:
					state <= MIDE_ST_RUN;
			endcase
		end
	end

	// issue handshake, registered from the next state: low in the jump dummy cycle and power-down
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			ready_o <= 1'b1;
		else
		begin
			case (state)
				MIDE_ST_RUN:
					ready_o <= !(take_jump || take_halt);
				MIDE_ST_DUMMY:
					ready_o <= 1'b1;
				MIDE_ST_HALT:
					ready_o <= wake_i;
				default:
					ready_o <= 1'b1;
			endcase
		end
	end

	// power-down status and clock gate, flopped so they change with the state itself
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			halted_o <= 1'b0;
			clk_gate_en_o <= 1'b1;
		end
		else
		begin
			case (state)
				MIDE_ST_RUN:
				begin
					halted_o <= take_halt;
					clk_gate_en_o <= !take_halt;
				end
				MIDE_ST_DUMMY:
				begin
					halted_o <= 1'b0;
					clk_gate_en_o <= 1'b1;
				end
				MIDE_ST_HALT:
				begin
					halted_o <= !wake_i;
					clk_gate_en_o <= wake_i;
				end
				default:
				begin
					halted_o <= 1'b0;
					clk_gate_en_o <= 1'b1;
				end
			endcase
		end
	end

	// program counter: step on each taken instruction except power-down, load on jump
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			pc_o <= `MIDE_PC_RST;
		else if (take)
		begin
			if (instr_i.op == MIDE_OP_JUMP)
				pc_o <= instr_i.target;
			else if (instr_i.op != MIDE_OP_HALT)
				pc_o <= pc_o + `MIDE_PC_STEP;
		end
	end

	// working register; untouched while halted so contents survive power-down
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			working_register_o <= `MIDE_ZERO_BYTE;
		else if (take)
		begin
			case (instr_i.op)
				MIDE_OP_DEC_WREG:
					working_register_o <= alu_res;
				MIDE_OP_INC_WREG:
					working_register_o <= alu_res;
				MIDE_OP_MOV_M2W:
					working_register_o <= mem_rd;
				MIDE_OP_MOV_IMM:
					working_register_o <= instr_i.imm;
				default:
					working_register_o <= working_register_o;
			endcase
		end
	end

	// data memory: no reset, so a reset-free power-down keeps every byte
	always_ff @(posedge clk_i)
	begin
		if (take)
		begin
			case (instr_i.op)
				MIDE_OP_DEC_MEM:
					data_mem[instr_i.addr] <= alu_res;
				MIDE_OP_INC_MEM:
					data_mem[instr_i.addr] <= alu_res;
				MIDE_OP_MOV_W2M:
					data_mem[instr_i.addr] <= working_register_o;
				default:
					data_mem[instr_i.addr] <= data_mem[instr_i.addr];
			endcase
		end
	end

	// mirror of memory writes for the rest of the core
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			mem_wr_o <= 1'b0;
			mem_addr_o <= `MIDE_ZERO_BYTE;
			mem_wdata_o <= `MIDE_ZERO_BYTE;
		end
		else
		begin
			mem_wr_o <= take && is_mem_write(instr_i.op);
			if (take)
			begin
				mem_addr_o <= instr_i.addr;
				mem_wdata_o <= (instr_i.op == MIDE_OP_MOV_W2M) ? working_register_o : alu_res;
			end
		end
	end

	// zero flag: only the four inc/dec forms touch it
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			zero_flag <= 1'b0;
		else if (take && is_incdec(instr_i.op))
			zero_flag <= alu_zero;
	end

	// power-down flag set by the power-down instruction, held until reset
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			power_down_flag <= 1'b0;
		else if (take_halt)
			power_down_flag <= 1'b1;
	end

	// timeout flag: watchdog expiry sets it, power-down clears it
	// the clear wins a same-cycle expiry, since power-down restarts the watchdog anyway
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			watchdog_timeout_flag <= 1'b0;
		else if (take_halt)
			watchdog_timeout_flag <= 1'b0;
		else if (watchdog_timeout_i)
			watchdog_timeout_flag <= 1'b1;
	end

	// watchdog count and prescaler: free-running, both cleared on power-down
	// both freeze while halted, as they would with the system clock gated off
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			watchdog_prescaler_o <= `MIDE_PRE_RST;
			watchdog_timer_o <= `MIDE_WDT_RST;
		end
		else if (take_halt)
		begin
			watchdog_prescaler_o <= `MIDE_PRE_RST;
			watchdog_timer_o <= `MIDE_WDT_RST;
		end
		else if (state != MIDE_ST_HALT)
		begin
			watchdog_prescaler_o <= watchdog_prescaler_o + `MIDE_PRE_W'(1);
			if (&watchdog_prescaler_o)
				watchdog_timer_o <= watchdog_timer_o + `MIDE_WDT_W'(1);
		end
	end
endmodule

// File: tb/mide_exec_checker.sv
// Purpose: temporal checks on the execution block ports
// Assumes: one clock, async active-low reset
// Notes: bound to every instance of mide_exec
`include "mide_consts.svh"
module mide_exec_checker
	import mide_pkg::*;
(
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic instr_valid_i,
	input wire mide_instr_t instr_i,
	input wire logic wake_i,
	input wire logic watchdog_timeout_i,
	input wire logic ready_o,
	input wire logic [`MIDE_PC_W-1:0] pc_o,
	input wire logic [`MIDE_DATA_W-1:0] working_register_o,
	input wire mide_flags_t flags_o,
	input wire logic clk_gate_en_o,
	input wire logic halted_o,
	input wire logic [`MIDE_WDT_W-1:0] watchdog_timer_o,
	input wire logic [`MIDE_PRE_W-1:0] watchdog_prescaler_o,
	input wire logic mem_wr_o,
	input wire logic [`MIDE_ADDR_W-1:0] mem_addr_o,
	input wire logic [`MIDE_DATA_W-1:0] mem_wdata_o
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!nrst_i);
	logic take;
	mide_op_t op;
	// accepted instruction on this edge
	assign take = instr_valid_i && ready_o;
	assign op = instr_i.op;
	jump_dummy_a: assert property (take && op == MIDE_OP_JUMP |=>
		pc_o == $past(instr_i.target) && !ready_o ##1 ready_o) else $error("jump timing");
	halt_enter_a: assert property (take && op == MIDE_OP_HALT |=> halted_o &&
		!clk_gate_en_o && flags_o.power_down_flag && !flags_o.watchdog_timeout_flag)
		else $error("halt entry");
	halt_wdt_a: assert property (take && op == MIDE_OP_HALT |=>
		watchdog_timer_o == `MIDE_WDT_RST && watchdog_prescaler_o == `MIDE_PRE_RST)
		else $error("wdt clear");
	halt_hold_a: assert property (halted_o && !wake_i |=>
		$stable(pc_o) && $stable(working_register_o) && !mem_wr_o) else $error("halt hold");
	mov_imm_a: assert property (take && op == MIDE_OP_MOV_IMM |=>
		working_register_o == $past(instr_i.imm)) else $error("move immediate");
	mov_store_a: assert property (take && op == MIDE_OP_MOV_W2M |=> mem_wr_o &&
		mem_addr_o == $past(instr_i.addr) && mem_wdata_o == $past(working_register_o))
		else $error("move to memory");
	mem_zero_a: assert property (
		take && (op == MIDE_OP_INC_MEM || op == MIDE_OP_DEC_MEM) |=>
		mem_wr_o && flags_o.zero == (mem_wdata_o == `MIDE_ZERO_BYTE)) else $error("mem inc dec");
	wreg_only_a: assert property (
		take && (op == MIDE_OP_INC_WREG || op == MIDE_OP_DEC_WREG) |=>
		!mem_wr_o && flags_o.zero == (working_register_o == `MIDE_ZERO_BYTE))
		else $error("wreg inc dec");
	flags_keep_a: assert property (
		take && (op == MIDE_OP_JUMP || op == MIDE_OP_MOV_M2W || op == MIDE_OP_MOV_IMM ||
		op == MIDE_OP_MOV_W2M) |=> $stable(flags_o.zero) && $stable(flags_o.power_down_flag))
		else $error("flags changed by jump or move");
	cover property (take && op == MIDE_OP_JUMP);
	cover property (halted_o && wake_i);
	cover property (take && op == MIDE_OP_DEC_MEM);
endmodule
bind mide_exec mide_exec_checker u_chk
(
	.clk_i(clk_i), .nrst_i(nrst_i), .instr_valid_i(instr_valid_i), .instr_i(instr_i),
	.wake_i(wake_i), .watchdog_timeout_i(watchdog_timeout_i), .ready_o(ready_o),
	.pc_o(pc_o), .working_register_o(working_register_o), .flags_o(flags_o),
	.clk_gate_en_o(clk_gate_en_o), .halted_o(halted_o),
	.watchdog_timer_o(watchdog_timer_o), .watchdog_prescaler_o(watchdog_prescaler_o),
	.mem_wr_o(mem_wr_o), .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o)
);

// File: tb/tb_mide_exec.sv
// Purpose: directed bench for the execution block
// Assumes: inputs change 1 ns after the rising edge
// Notes: memory starts unknown, so scenarios write before they read
`include "mide_consts.svh"
module tb_mide_exec
	import mide_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_i, nrst_i, instr_valid_i, wake_i, watchdog_timeout_i;
	logic ready_o, clk_gate_en_o, halted_o, mem_wr_o;
	mide_instr_t instr_i;
	mide_flags_t flags_o;
	logic [`MIDE_PC_W-1:0] pc_o;
	logic [`MIDE_DATA_W-1:0] working_register_o, mem_wdata_o;
	logic [`MIDE_ADDR_W-1:0] mem_addr_o;
	logic [`MIDE_WDT_W-1:0] watchdog_timer_o;
	logic [`MIDE_PRE_W-1:0] watchdog_prescaler_o;
	int num_errors = 0;
	int compares = 0;
	mide_exec u_dut
	(
		.clk_i(clk_i), .nrst_i(nrst_i), .instr_valid_i(instr_valid_i), .instr_i(instr_i),
		.wake_i(wake_i), .watchdog_timeout_i(watchdog_timeout_i), .ready_o(ready_o),
		.pc_o(pc_o), .working_register_o(working_register_o), .flags_o(flags_o),
		.clk_gate_en_o(clk_gate_en_o), .halted_o(halted_o),
		.watchdog_timer_o(watchdog_timer_o), .watchdog_prescaler_o(watchdog_prescaler_o),
		.mem_wr_o(mem_wr_o), .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o)
	);
	// 200 MHz clock
	initial
	begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		compares++;
		if (g !== e)
		begin
			num_errors++;
			$display("[FAIL] %s exp %h got %h", n, e, g);
		end
	endtask
	// valid stays up so back-to-back issues never toggle it twice in one step
	task automatic issue(input mide_op_t op, input logic [7:0] a, input logic [7:0] x);
		instr_i = '{op: op, addr: a, imm: x, target: 11'h5A5};
		instr_valid_i = 1'b1;
		@(posedge clk_i);
		#1;
	endtask
	task automatic idle();
		instr_valid_i = 1'b0;
		@(posedge clk_i);
		#1;
	endtask
	task automatic step(input mide_op_t op, input logic [7:0] a, input logic [7:0] x,
		input logic [7:0] w, input logic z);
		issue(op, a, x);
		chk("wreg", 16'(w), 16'(working_register_o));
		chk("zero", 16'(z), 16'(flags_o.zero));
	endtask
	task automatic t_incdec();
		step(MIDE_OP_MOV_IMM, 8'h00, 8'hFF, 8'hFF, 1'b0);
		step(MIDE_OP_MOV_W2M, 8'h10, 8'h00, 8'hFF, 1'b0);
		chk("wdata", 16'h00FF, 16'(mem_wdata_o));
		step(MIDE_OP_INC_MEM, 8'h10, 8'h00, 8'hFF, 1'b1);
		chk("wdata", 16'h0000, 16'(mem_wdata_o));
		step(MIDE_OP_MOV_M2W, 8'h10, 8'h00, 8'h00, 1'b1);
		step(MIDE_OP_DEC_WREG, 8'h10, 8'h00, 8'hFF, 1'b0);
		chk("wr", 16'h0000, 16'(mem_wr_o));
		step(MIDE_OP_MOV_M2W, 8'h10, 8'h00, 8'h00, 1'b0);
		step(MIDE_OP_INC_WREG, 8'h10, 8'h00, 8'h01, 1'b0);
		step(MIDE_OP_DEC_MEM, 8'h10, 8'h00, 8'h01, 1'b0);
		chk("wdata", 16'h00FF, 16'(mem_wdata_o));
		step(MIDE_OP_INC_WREG, 8'h10, 8'h00, 8'h00, 1'b1);
		step(MIDE_OP_MOV_IMM, 8'h00, 8'h01, 8'h01, 1'b1);
		step(MIDE_OP_MOV_W2M, 8'h20, 8'h00, 8'h01, 1'b1);
		step(MIDE_OP_DEC_MEM, 8'h20, 8'h00, 8'h01, 1'b1);
		chk("wdata", 16'h0000, 16'(mem_wdata_o));
		idle();
	endtask
	task automatic t_jump();
		issue(MIDE_OP_JUMP, 8'h00, 8'h00);
		chk("pc", 16'h05A5, 16'(pc_o));
		chk("ready", 16'h0000, 16'(ready_o));
		chk("zero", 16'h0001, 16'(flags_o.zero));
		// a move offered in the dummy cycle must be refused
		issue(MIDE_OP_MOV_IMM, 8'h00, 8'h33);
		chk("ready", 16'h0001, 16'(ready_o));
		chk("wreg", 16'h0001, 16'(working_register_o));
		chk("pc", 16'h05A5, 16'(pc_o));
		idle();
	endtask
	task automatic t_halt();
		// long enough for the prescaler to wrap, so the timer clear below means something
		repeat (256) idle();
		chk("wdt_run", 16'h0001, 16'(watchdog_timer_o != `MIDE_WDT_RST));
		watchdog_timeout_i = 1'b1;
		idle();
		watchdog_timeout_i = 1'b0;
		chk("to", 16'h0001, 16'(flags_o.watchdog_timeout_flag));
		issue(MIDE_OP_HALT, 8'h00, 8'h00);
		chk("halted", 16'h0001, 16'(halted_o));
		chk("gate", 16'h0000, 16'(clk_gate_en_o));
		chk("flags", 16'h0002, 16'(flags_o[1:0]));
		chk("wdt", 16'h0000, 16'(watchdog_timer_o));
		chk("pre", 16'h0000, 16'(watchdog_prescaler_o));
		// an offered move must be refused while powered down
		repeat (3) issue(MIDE_OP_MOV_IMM, 8'h00, 8'h77);
		chk("wreg", 16'h0001, 16'(working_register_o));
		wake_i = 1'b1;
		idle();
		wake_i = 1'b0;
		chk("ready", 16'h0001, 16'(ready_o));
		step(MIDE_OP_MOV_M2W, 8'h10, 8'h00, 8'hFF, 1'b1);
		idle();
	endtask
	// mid-run reset: power-down flag, pc, working register and prescaler return to reset values, then issue resumes at once
	task automatic t_reset();
		nrst_i = 1'b0;
		@(posedge clk_i);
		#1;
		chk("pdf", 16'h0000, 16'(flags_o.power_down_flag));
		chk("pc", 16'h0000, 16'(pc_o));
		chk("wreg", 16'h0000, 16'(working_register_o));
		chk("pre", 16'h0000, 16'(watchdog_prescaler_o));
		nrst_i = 1'b1;
		step(MIDE_OP_MOV_IMM, 8'h00, 8'h5A, 8'h5A, 1'b0);
		chk("pc", 16'h0001, 16'(pc_o));
		idle();
	endtask
	task automatic give_verdict();
		$display("compares %0d num_errors %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// main sequence
	initial
	begin
		nrst_i = 1'b0;
		instr_valid_i = 1'b0;
		wake_i = 1'b0;
		watchdog_timeout_i = 1'b0;
		instr_i = '0;
		repeat (10) @(posedge clk_i);
		#1;
		nrst_i = 1'b1;
		chk("pc", 16'h0000, 16'(pc_o));
		t_incdec();
		t_jump();
		t_halt();
		t_reset();
		give_verdict();
	end
	// hang guard, far beyond the ~290 cycles the scenarios need
	initial
	begin
		#20000;
		num_errors++;
		give_verdict();
	end
endmodule
